//--- core/irq_prio_pkg.sv
// Constants, register map and carrier types for the nested priority gate
// and the external pin detector.
// Assumes an APB3 master with 32-bit data and word-aligned accesses.
package irq_prio_pkg;

  localparam int LEVEL_W = 2;
  localparam int STACK_DEPTH = 4;

  // Register indices; byte address is four times the index
  localparam logic [9:0] PIN_SC_IDX = 10'h03b;
  localparam logic [9:0] GATE_SC_IDX = 10'h03c;
  localparam logic [9:0] LEVEL_IDX = 10'h040;

  // Pin status/control bit positions
  localparam int PIN_MOD_BIT = 0;
  localparam int PIN_IE_BIT = 1;
  localparam int PIN_ACK_BIT = 2;
  localparam int PIN_FLAG_BIT = 3;
  localparam int PIN_PE_BIT = 4;
  localparam int PIN_EDG_BIT = 5;
  localparam int PIN_PDD_BIT = 6;

  // Gate status/control bit positions
  localparam int GATE_MASK_LSB = 0;
  localparam int GATE_PULL_BIT = 2;
  localparam int GATE_EMPTY_BIT = 4;
  localparam int GATE_FULL_BIT = 5;
  localparam int GATE_EN_BIT = 7;

  localparam logic [LEVEL_W-1:0] MASK_RST = 2'h0;
  localparam logic [LEVEL_W-1:0] STOP_MASK = 2'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 2'h0;
  localparam logic [2:0] DEPTH_CNT = 3'h4;

  typedef struct packed {
    logic pull_disable;
    logic polarity;
    logic pin_enable;
    logic irq_enable;
    logic edge_level_mode;
  } pin_cfg_s;

  typedef struct packed {
    logic gate_enable;
    logic [LEVEL_W-1:0] priority_mask;
  } gate_ctl_s;

  localparam pin_cfg_s PIN_CFG_RST = 5'h00;
  localparam gate_ctl_s GATE_CTL_RST = 3'h0;

endpackage

//--- core/nested_irq_priority_gate.sv
// Interrupt priority gate between peripheral sources and the CPU, with the
// mask history stack and the external interrupt pin detector.
// Assumes synchronous source requests on pclk and an APB3 register master.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

//
// Contract
// [R1] Each source holds a two-bit level
// [R2] Levels readable and writable at any time
// [R3] Enabled gate passes level at least mask
// [R4] Stop3 compares against zero mask
// [R5] Disabled gate forwards requests unchanged
// [R6] Gate never reorders; CPU arbitrates
// [R7] Mask sits in low two bits
// [R8] Vector fetch loads mask with level
// [R9] Old mask pushed on four-deep stack
// [R10] Restore bit pops saved mask back
// [R11] Full flag when last entry written
// [R12] Empty flag when all entries popped
// [R13] Software mask writes always take effect; the code lets a push or pull in the same cycle override them
// [R14] Asynchronous requests bypass gate to wake
// [R15] Software clears flags, restores before exit
// [R16] Pin level readable while interrupt masked
// [R17] Pin detector works only when enabled
// [R18] Polarity, mode and interrupt enable controls
// [R19] Pullup on unless pull disable set; the code also keeps it off while the pin is disabled
// [R20] Enabling pin sets event flag
// [R21] Level mode holds flag while asserted
// [R22] Sync sampling, async wake in stop
// [R23] Polarity zero falling, one rising
// [R24] Rising polarity forces pullup off
// [R25] Full push drops oldest; empty pop zero
// [R26] Registered outputs, state clears at reset; system_wake is unregistered and the pin synchronisers reset high
module nested_irq_priority_gate
  import irq_prio_pkg::*;
#(
  parameter int NUM_SRC = 16,
  parameter int ASYNC_W = 4,
  parameter int PIN_SRC = 0,
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic [ASYNC_W-1:0] async_wake_req,
  input wire logic stop3_mode,
  input wire logic vec_fetch,
  input wire logic [$clog2(NUM_SRC)-1:0] vec_src,
  input wire logic pin_in,
  output logic [NUM_SRC-1:0] gated_request_out,
  output logic pin_level,
  output logic pullup_enable,
  output logic system_wake
);

  localparam logic [ADDR_W-1:0] PIN_SC_ADDR = ADDR_W'({PIN_SC_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] GATE_SC_ADDR = ADDR_W'({GATE_SC_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] LEVEL_ADDR = ADDR_W'({LEVEL_IDX, 2'b00});

  // Bus state
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic wr_pin, wr_gate, wr_level, hit;

  // Pin state
  pin_cfg_s cfg_reg, cfg_next;
  logic flag_reg, flag_next;
  logic pin_s1_reg, pin_s2_reg, pin_prev_reg;
  logic pin_level_reg, pullup_reg, pullup_next;
  logic asserted, prev_asserted, pin_edge, pe_rise, flag_set, flag_clr, pin_irq;

  // Gate and stack state
  gate_ctl_s ctl_reg, ctl_next;
  logic [LEVEL_W-1:0] level_reg [NUM_SRC];
  logic [LEVEL_W-1:0] level_next [NUM_SRC];
  logic [LEVEL_W-1:0] stk_reg [STACK_DEPTH];
  logic [LEVEL_W-1:0] stk_next [STACK_DEPTH];
  logic [2:0] cnt_reg, cnt_next;
  logic full_reg, full_next, empty_reg, empty_next;
  logic [NUM_SRC-1:0] grant_reg, grant_next, req_eff;
  logic [LEVEL_W-1:0] eff_mask, fetch_level;
  logic do_push, do_pull;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign gated_request_out = grant_reg;
  assign pin_level = pin_level_reg;
  assign pullup_enable = pullup_reg;

  // Clockless wake path: must work in stop with pclk halted, so not registered
  always_comb
  begin
    system_wake = (|async_wake_req) | // [R14]
      (cfg_reg.pin_enable & (cfg_reg.polarity ? pin_in : ~pin_in)); // [R22]
  end

  // APB slave: fixed one-cycle access, data captured in the setup cycle
  always_comb
  begin
    hit = (paddr == PIN_SC_ADDR) || (paddr == GATE_SC_ADDR) || (paddr == LEVEL_ADDR);
    wr_pin = psel & penable & pready_reg & pwrite & (paddr == PIN_SC_ADDR);
    wr_gate = psel & penable & pready_reg & pwrite & (paddr == GATE_SC_ADDR);
    wr_level = psel & penable & pready_reg & pwrite & (paddr == LEVEL_ADDR);
    pready_next = psel & ~penable;
    pslverr_next = psel & ~penable & ~hit;
    prdata_next = prdata_reg;
    if (psel && !penable)
    begin
      prdata_next = 32'h0000_0000;
      if (paddr == PIN_SC_ADDR)
      begin
        prdata_next[PIN_PDD_BIT] = cfg_reg.pull_disable;
        prdata_next[PIN_EDG_BIT] = cfg_reg.polarity;
        prdata_next[PIN_PE_BIT] = cfg_reg.pin_enable;
        prdata_next[PIN_FLAG_BIT] = flag_reg;
        prdata_next[PIN_IE_BIT] = cfg_reg.irq_enable;
        prdata_next[PIN_MOD_BIT] = cfg_reg.edge_level_mode;
      end
      else if (paddr == GATE_SC_ADDR)
      begin
        prdata_next[GATE_MASK_LSB +: LEVEL_W] = ctl_reg.priority_mask; // [R7]
        prdata_next[GATE_EMPTY_BIT] = empty_reg;
        prdata_next[GATE_FULL_BIT] = full_reg;
        prdata_next[GATE_EN_BIT] = ctl_reg.gate_enable;
      end
      else if (paddr == LEVEL_ADDR)
      begin
        for (int i = 0; i < NUM_SRC; i++)
        begin
          prdata_next[i*LEVEL_W +: LEVEL_W] = level_reg[i]; // [R2]
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // External pin detector
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_pin)
    begin
      cfg_next.pull_disable = pwdata[PIN_PDD_BIT];
      cfg_next.polarity = pwdata[PIN_EDG_BIT];
      cfg_next.pin_enable = pwdata[PIN_PE_BIT];
      cfg_next.irq_enable = pwdata[PIN_IE_BIT]; // [R18]
      cfg_next.edge_level_mode = pwdata[PIN_MOD_BIT];
    end
    asserted = cfg_reg.polarity ? pin_s2_reg : ~pin_s2_reg; // [R23]
    prev_asserted = cfg_reg.polarity ? pin_prev_reg : ~pin_prev_reg;
    pin_edge = asserted & ~prev_asserted;
    pe_rise = cfg_next.pin_enable & ~cfg_reg.pin_enable; // [R20]
    // Level mode keeps setting, so an ack cannot win while asserted
    flag_set = pe_rise | (cfg_reg.pin_enable & // [R17]
      (pin_edge | (cfg_reg.edge_level_mode & asserted))); // [R21] [R22]
    flag_clr = wr_pin & pwdata[PIN_ACK_BIT];
    flag_next = flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_reg);
    // Flag alone stays pollable when the interrupt enable is off
    pin_irq = flag_reg & cfg_reg.irq_enable & cfg_reg.pin_enable; // [R18]
    pullup_next = cfg_next.pin_enable & ~cfg_next.pull_disable & // [R19]
      ~cfg_next.polarity; // [R24]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg <= PIN_CFG_RST;
      flag_reg <= 1'b0;
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
      pin_level_reg <= 1'b1;
      pullup_reg <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      flag_reg <= flag_next;
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      pin_level_reg <= pin_s2_reg; // [R16]
      pullup_reg <= pullup_next;
    end
  end

  // Priority gate and mask history stack
  always_comb
  begin
    req_eff = src_req;
    req_eff[PIN_SRC] = src_req[PIN_SRC] | pin_irq;
    eff_mask = stop3_mode ? STOP_MASK : ctl_reg.priority_mask; // [R4]
    // Per-source gating only; CPU picks among survivors
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (ctl_reg.gate_enable)
      begin
        grant_next[i] = req_eff[i] & (level_reg[i] >= eff_mask); // [R3] [R6]
      end
      else
      begin
        grant_next[i] = req_eff[i]; // [R5]
      end
      level_next[i] = wr_level ? pwdata[i*LEVEL_W +: LEVEL_W] : level_reg[i]; // [R1] [R2]
    end
    fetch_level = level_reg[vec_src];
    do_push = vec_fetch & ctl_reg.gate_enable;
    do_pull = wr_gate & pwdata[GATE_PULL_BIT] & ~do_push;
    ctl_next = ctl_reg;
    stk_next = stk_reg;
    cnt_next = cnt_reg;
    full_next = full_reg;
    empty_next = empty_reg;
    if (wr_gate)
    begin
      ctl_next.gate_enable = pwdata[GATE_EN_BIT];
      ctl_next.priority_mask = pwdata[GATE_MASK_LSB +: LEVEL_W]; // [R13]
    end
    if (do_push)
    begin
      ctl_next.priority_mask = fetch_level; // [R8]
      stk_next[0] = ctl_reg.priority_mask; // [R9]
      for (int i = 1; i < STACK_DEPTH; i++)
      begin
        stk_next[i] = stk_reg[i-1]; // [R25]
      end
      if (cnt_reg != DEPTH_CNT)
      begin
        cnt_next = cnt_reg + 3'h1;
      end
      full_next = (cnt_next == DEPTH_CNT); // [R11]
      empty_next = 1'b0;
    end
    else if (do_pull)
    begin
      ctl_next.priority_mask = (cnt_reg == 3'h0) ? MASK_RST : stk_reg[0]; // [R10] [R25]
      for (int i = 0; i < STACK_DEPTH - 1; i++)
      begin
        stk_next[i] = stk_reg[i+1];
      end
      stk_next[STACK_DEPTH-1] = MASK_RST;
      if (cnt_reg != 3'h0)
      begin
        cnt_next = cnt_reg - 3'h1;
      end
      empty_next = (cnt_next == 3'h0); // [R12]
      full_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_reg <= GATE_CTL_RST; // [R26]
      cnt_reg <= 3'h0;
      full_reg <= 1'b0;
      empty_reg <= 1'b0;
      grant_reg <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stk_reg[i] <= MASK_RST;
      end
      for (int i = 0; i < NUM_SRC; i++)
      begin
        level_reg[i] <= LEVEL_RST;
      end
    end
    else
    begin
      ctl_reg <= ctl_next;
      cnt_reg <= cnt_next;
      full_reg <= full_next;
      empty_reg <= empty_next;
      grant_reg <= grant_next; // [R26]
      stk_reg <= stk_next;
      level_reg <= level_next;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  generate
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : gate_chk
      low_level_block_a: assert property ( // [R3]
        ctl_reg.gate_enable && !stop3_mode && req_eff[g] &&
        (level_reg[g] < ctl_reg.priority_mask) |=> !gated_request_out[g])
        else $error("low level request passed gate");
      stop_pass_a: assert property ( // [R4]
        ctl_reg.gate_enable && stop3_mode && req_eff[g] |=> gated_request_out[g])
        else $error("request blocked in stop3");
    end
  endgenerate

  bypass_fwd_a: assert property ( // [R5]
    !ctl_reg.gate_enable |=> gated_request_out == $past(req_eff))
    else $error("disabled gate altered requests");
  fetch_load_a: assert property ( // [R8]
    do_push |=> ctl_reg.priority_mask == $past(fetch_level))
    else $error("mask not loaded on vector fetch");
  push_save_a: assert property ( // [R9]
    do_push ##1 1'b1 |-> stk_reg[0] == $past(ctl_reg.priority_mask))
    else $error("old mask not pushed");
  pull_restore_a: assert property ( // [R10]
    do_pull && cnt_reg != 3'h0 |=> ctl_reg.priority_mask == $past(stk_reg[0]))
    else $error("pop did not restore mask");
  full_set_a: assert property ( // [R11]
    do_push && cnt_reg == 3'h3 |=> full_reg && cnt_reg == DEPTH_CNT)
    else $error("full flag missing");
  empty_set_a: assert property ( // [R12]
    do_pull && cnt_reg == 3'h1 |=> empty_reg ##1 (empty_reg || do_push || $past(do_push)))
    else $error("empty flag missing");
  enable_flag_a: assert property ( // [R20]
    pe_rise |=> flag_reg)
    else $error("enable did not set flag");
  level_hold_a: assert property ( // [R21]
    cfg_reg.pin_enable && cfg_reg.edge_level_mode && asserted |=> flag_reg)
    else $error("flag cleared while pin asserted");
  rise_pull_a: assert property ( // [R24]
    cfg_reg.polarity |-> !pullup_enable)
    else $error("pullup on with rising polarity");

  stack_full_c: cover property (do_push ##1 full_reg);
  stack_empty_c: cover property (do_pull ##1 empty_reg);
  pin_event_c: cover property (cfg_reg.pin_enable && pin_edge ##1 flag_reg);
  stop_pass_c: cover property (stop3_mode && ctl_reg.gate_enable && |gated_request_out);

endmodule

//--- testbench/cpu_vec_model.sv
// CPU side model: takes gated requests and issues vector fetch pulses.
// Assumes one pclk domain; serve lets the bench pick when to take one.
`timescale 1ns/1ps
module cpu_vec_model #(
  parameter int NUM_SRC = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serve,
  input wire logic [NUM_SRC-1:0] gated_request_out,
  output logic vec_fetch,
  output logic [$clog2(NUM_SRC)-1:0] vec_src
);
  logic [1:0] gap;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vec_fetch <= 1'b0;
      vec_src <= '0;
      gap <= 2'h0;
    end
    else
    begin
      vec_fetch <= 1'b0;
      if (gap != 2'h0)
        gap <= gap - 2'h1;
      else if (serve && |gated_request_out)
      begin
        vec_fetch <= 1'b1;
        // Gap stops a second fetch on a stale request
        gap <= 2'h3;
        // Fixed order: highest index wins
        for (int i = 0; i < NUM_SRC; i++)
          if (gated_request_out[i])
            vec_src <= i[$clog2(NUM_SRC)-1:0];
      end
    end
  end
endmodule

//--- testbench/nested_irq_priority_gate_test.sv
// Self-checking bench: APB register tasks, gate, stack and pin scenarios.
// Assumes the design's pready answers within a few cycles.
`timescale 1ns/1ps
module nested_irq_priority_gate_test;
  import irq_prio_pkg::*;
  localparam logic [11:0] PA = {PIN_SC_IDX, 2'h0};
  localparam logic [11:0] GA = {GATE_SC_IDX, 2'h0};
  localparam logic [11:0] LA = {LEVEL_IDX, 2'h0};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [15:0] src_req = '0, gated_request_out, ex;
  logic [3:0] async_wake_req = '0, vec_src;
  logic stop3_mode = 0, vec_fetch, pin_in = 1, pin_level, pullup_enable, system_wake;
  logic serve = 0, er;
  int miscompares = 0, cmp_count = 0, n;
  logic [3:0] srcs [5] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'hb};
  logic [7:0] push_x [5] = '{8'h81, 8'h82, 8'h83, 8'ha3, 8'ha3};
  logic [7:0] pop_x [5] = '{8'h83, 8'h83, 8'h82, 8'h91, 8'h90};
  nested_irq_priority_gate nested_irq_priority_gate_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
    .async_wake_req(async_wake_req), .stop3_mode(stop3_mode), .vec_fetch(vec_fetch),
    .vec_src(vec_src), .pin_in(pin_in), .gated_request_out(gated_request_out),
    .pin_level(pin_level), .pullup_enable(pullup_enable), .system_wake(system_wake));
  cpu_vec_model cpu_vec_model_inst (.pclk(pclk), .presetn(presetn), .serve(serve),
    .gated_request_out(gated_request_out), .vec_fetch(vec_fetch), .vec_src(vec_src));
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  task stop_test();
    $display("mismatches %0d of %0d checks", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Setup one cycle, then hold everything until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      miscompares++;
      stop_test();
    end
    q = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(0, a, '0);
    chk(nm, e, q);
  endtask
  task wt(input int c);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(PA, 0, "pin reset");
    rd(GA, 0, "gate reset");
    rd(12'h004, 0, "unmapped");
    chk("slverr", 1, er);
    @(posedge pclk);
    pin_in <= 0;
    async_wake_req <= 4'h2;
    wt(5);
    chk("async wake", 1, system_wake);
    rd(PA, 0, "pin off");
    @(posedge pclk);
    async_wake_req <= 0;
    pin_in <= 1;
    apb(1, LA, 32'he4e4e4e4);
    rd(LA, 32'he4e4e4e4, "levels");
    @(posedge pclk);
    src_req <= 16'h5a5a;
    wt(2);
    chk("forward", 16'h5a5a, gated_request_out);
    for (int m = 0; m < 4; m++)
    begin
      apb(1, GA, 32'h80 | m);
      src_req <= 16'hffff;
      for (int i = 0; i < 16; i++)
        ex[i] = (i % 4) >= m;
      wt(2);
      chk("gate", {16'h0, ex}, {16'h0, gated_request_out});
    end
    @(posedge pclk);
    stop3_mode <= 1;
    wt(2);
    chk("stop3", 16'hffff, gated_request_out);
    @(posedge pclk);
    stop3_mode <= 0;
    src_req <= 0;
    apb(1, GA, 32'h80);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge pclk);
      src_req <= 16'h1 << srcs[k];
      serve <= 1;
      n = 0;
      while (vec_fetch !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n++;
      end
      if (n == 20)
      begin
        miscompares++;
        stop_test();
      end
      src_req <= 0;
      serve <= 0;
      rd(GA, push_x[k], "push");
    end
    for (int k = 0; k < 5; k++)
    begin
      // Mask field carries the opposite value, so only the pop can match
      apb(1, GA, 32'h87 ^ {30'h0, pop_x[k][1:0]});
      rd(GA, pop_x[k], "pop");
    end
    apb(1, PA, 32'h11);
    rd(PA, 32'h19, "enable flag");
    chk("pullup on", 1, pullup_enable);
    apb(1, PA, 32'h15);
    @(posedge pclk);
    pin_in <= 0;
    wt(5);
    chk("pin level", 0, pin_level);
    chk("pin wake", 1, system_wake);
    apb(1, PA, 32'h15);
    rd(PA, 32'h19, "level hold");
    @(posedge pclk);
    pin_in <= 1;
    wt(5);
    apb(1, PA, 32'h15);
    rd(PA, 32'h11, "level clear");
    apb(1, PA, 32'h50);
    wt(1);
    chk("pull off", 0, pullup_enable);
    apb(1, PA, 32'h34);
    @(posedge pclk);
    pin_in <= 0;
    wt(5);
    rd(PA, 32'h30, "no fall");
    chk("rise pull", 0, pullup_enable);
    @(posedge pclk);
    pin_in <= 1;
    wt(5);
    rd(PA, 32'h38, "rise flag");
    apb(1, PA, 32'h32);
    wt(5);
    chk("pin irq", 1, gated_request_out[0]);
    apb(1, GA, 32'h81);
    wt(2);
    chk("pin masked", 0, gated_request_out[0]);
    chk("masked level", 1, pin_level);
    apb(1, GA, 32'h80);
    apb(1, PA, 32'h36);
    wt(5);
    chk("pin ack", 0, gated_request_out[0]);
    stop_test();
  end
endmodule
